// [logic/dsp_core_operation_unit.sv]
module dsp_core_operation_unit
  import dsp_core_pkg::*;
#(
  parameter int RECOVER_CYCLES = STOP_RECOVER_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Instruction memory
  output logic [15:0] pc_out,
  input wire logic [31:0] instr_in,
  // Data memory
  output logic rd_en_out,
  output logic [15:0] rd_addr_out,
  input wire logic [15:0] rd_data_in,
  output logic wr_en_out,
  output logic [15:0] wr_addr_out,
  output logic [15:0] wr_data_out,
  // Interrupt sources
  input wire logic [NUM_EXT_IRQ-1:0] ext_irq_n_in,
  input wire logic [NUM_INT_IRQ-1:0] periph_irq_in,
  // Status
  output logic res_we_out,
  output logic [2:0] res_idx_out,
  output logic [GPR_W-1:0] res_data_out,
  output logic halted_out,
  output logic stopped_out,
  output logic stack_fault_out
);
  localparam int WAKE_BOUND = HALT_WAKE_CYCLES + 3;

  logic [1:0] rst_sync_r;
  logic rst_n;
  core_state_t state_r, state_nxt;
  logic [19:0] wait_cnt_r;
  logic run;
  logic [15:0] pc_r, pc_nxt, if_pc_r;
  logic if_v_r;
  logic [4:0] id_op;
  logic [2:0] id_dst, id_sa, id_sb;
  logic ex_v_r;
  logic [4:0] ex_op_r;
  logic [2:0] ex_dst_r;
  logic [15:0] ex_imm_r, ex_pc_r, ex_addr_r;
  logic [1:0] ex_part_r;
  logic [GPR_W-1:0] ex_a_r, ex_b_r, ex_d_r, ex_result;
  logic ex_wr, redirect, irq_take, kill;
  logic [15:0] redirect_pc;
  logic [GPR_W-1:0] gpr_r [NUM_GPR];
  logic [15:0] dp_r [NUM_DP];
  logic [15:0] cstk_r [CALL_DEPTH];
  logic [3:0] csp_r;
  logic [15:0] lstart_r [LOOP_DEPTH];
  logic [15:0] lend_r [LOOP_DEPTH];
  logic [15:0] lcnt_r [LOOP_DEPTH];
  logic [2:0] lsp_r;
  logic [1:0] ltop;
  logic loop_hit;
  logic [NUM_EXT_IRQ-1:0] ext_s1_r, ext_s2_r, ext_s3_r, ext_lvl_r, ext_fall;
  logic [NUM_IRQ-1:0] irq_pend_r, irq_en_r, irq_vec;
  logic [3:0] irq_idx;
  logic gie_r;
  logic [16:0] mul_op1, mul_op2;
  logic signed [33:0] product;
  logic signed [GPR_W-1:0] prod_ext, prod_sh;

  function automatic logic writes_gpr(input logic [4:0] op);
    return op inside {OP_MAC, OP_ADD, OP_SUB, OP_SHR, OP_EXP, OP_LDI, OP_LD};
  endfunction : writes_gpr

  function automatic logic [GPR_W-1:0] fwd(input logic [2:0] idx);
    if (ex_wr && ex_dst_r == idx) return ex_result;
    return gpr_r[idx];
  endfunction : fwd

  function automatic logic [GPR_W-1:0] load_view(input logic [1:0] part, input logic [GPR_W-1:0] d,
                                                 input logic [15:0] data);
    unique case (part)
      PART_LOW: return {d[39:16], data};
      PART_HIGH: return {d[39:32], data, d[15:0]};
      PART_GUARD: return {data[7:0], d[31:0]};
      PART_SEXT: return {{8{data[15]}}, data, 16'h0000};
    endcase
  endfunction : load_view

  function automatic logic [15:0] store_view(input logic [1:0] part, input logic [GPR_W-1:0] a);
    unique case (part)
      PART_HIGH, PART_SEXT: return a[31:16];
      PART_GUARD: return {8'h00, a[39:32]};
      PART_LOW: return a[15:0];
    endcase
  endfunction : store_view

  function automatic logic [4:0] sign_count(input logic [31:0] v);
    logic [4:0] n;
    logic same;
    n = 5'h00;
    same = 1'b1;
    for (int i = 30; i >= 0; i--) begin
      same = same && (v[i] == v[31]);
      if (same) n = n + 5'h01;
    end
    return n;
  endfunction : sign_count

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) rst_sync_r <= 2'h0;
    else rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // Core state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_BOOT: if (wait_cnt_r == 20'(RECOVER_CYCLES - 1)) state_nxt = ST_RUN;
      ST_RUN: begin
        if (ex_v_r && ex_op_r == OP_HALT) state_nxt = ST_HALT;
        else if (ex_v_r && ex_op_r == OP_STOP) state_nxt = ST_STOP;
      end
      ST_HALT: if (|irq_vec) state_nxt = ST_WAKE;
      ST_WAKE: if (wait_cnt_r == 20'(HALT_WAKE_CYCLES - 1)) state_nxt = ST_RUN;
      ST_STOP: state_nxt = ST_STOP;
      default: state_nxt = ST_BOOT;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_BOOT;
      wait_cnt_r <= 20'h00000;
      halted_out <= 1'b0;
      stopped_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wait_cnt_r <= (state_nxt != state_r) ? 20'h00000 : wait_cnt_r + 20'h00001;
      halted_out <= (state_nxt == ST_HALT);
      stopped_out <= (state_nxt == ST_STOP);
    end
  end
  assign run = (state_r == ST_RUN);

  // Decode of the fetched word
  assign id_op = instr_in[OPC_LSB +: 5];
  assign id_dst = instr_in[DST_LSB +: 3];
  assign id_sa = instr_in[SA_LSB +: 3];
  assign id_sb = instr_in[SB_LSB +: 3];

  // Execute stage arithmetic
  always_comb begin
    mul_op1 = (ex_imm_r[MUL_MODE_LSB +: 2] == MUL_UU) ? {1'b0, ex_a_r[15:0]} : {ex_a_r[31], ex_a_r[31:16]};
    mul_op2 = (ex_imm_r[MUL_MODE_LSB +: 2] == MUL_SS) ? {ex_b_r[31], ex_b_r[31:16]} : {1'b0, ex_b_r[15:0]};
    product = $signed(mul_op1) * $signed(mul_op2);
    prod_ext = {{6{product[33]}}, product};
    unique case (ex_imm_r[MAC_SH_LSB +: 2])
      SH_1: prod_sh = prod_ext >>> 1;
      SH_16: prod_sh = prod_ext >>> 16;
      default: prod_sh = prod_ext;
    endcase
    unique case (ex_op_r)
      OP_MAC: ex_result = ex_imm_r[MAC_SUB_BIT] ? ex_d_r - prod_sh : ex_d_r + prod_sh;
      OP_ADD: ex_result = ex_a_r + ex_b_r;
      OP_SUB: ex_result = ex_a_r - ex_b_r;
      OP_SHR: ex_result = $signed(ex_a_r) >>> ex_b_r[15:0];
      OP_EXP: ex_result = {35'h0, sign_count(ex_a_r[31:0])};
      OP_LDI: ex_result = {ex_d_r[39:16], ex_imm_r};
      OP_LD: ex_result = load_view(ex_part_r, ex_d_r, rd_data_in);
      default: ex_result = ex_d_r;
    endcase
  end
  assign ex_wr = ex_v_r && writes_gpr(ex_op_r);

  // Program flow
  always_comb begin
    redirect = run && ex_v_r && (ex_op_r inside {OP_JMP, OP_CALL, OP_RET, OP_RETI, OP_HALT, OP_STOP});
    unique case (ex_op_r)
      OP_JMP, OP_CALL: redirect_pc = ex_imm_r;
      // An empty stack falls through so the fetch address stays defined
      OP_RET, OP_RETI: redirect_pc = (csp_r != 4'h0) ? cstk_r[4'(csp_r - 4'h1)] : ex_pc_r + 16'h0001;
      default: redirect_pc = ex_pc_r + 16'h0001;
    endcase
  end
  assign irq_vec = irq_pend_r & irq_en_r;
  assign irq_take = run && gie_r && (|irq_vec) && !redirect;
  assign kill = irq_take || redirect;
  assign ltop = 2'(lsp_r - 3'h1);
  assign loop_hit = run && !kill && lsp_r != 3'h0 && pc_r == lend_r[ltop];
  always_comb begin
    if (irq_take) pc_nxt = VEC_BASE + 16'({irq_idx, 2'b00});
    else if (redirect) pc_nxt = redirect_pc;
    else if (loop_hit && lcnt_r[ltop] > 16'h0001) pc_nxt = lstart_r[ltop];
    else pc_nxt = pc_r + 16'h0001;
  end

  // Fetch stage
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pc_r <= PC_RESET;
      if_pc_r <= PC_RESET;
      if_v_r <= 1'b0;
    end else if (run) begin
      pc_r <= pc_nxt;
      if_pc_r <= pc_r;
      if_v_r <= !kill;
    end else begin
      if_v_r <= 1'b0;
    end
  end
  assign pc_out = pc_r;

  // Decode into execute registers
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ex_v_r <= 1'b0;
      ex_op_r <= OP_NOP;
      ex_dst_r <= 3'h0;
      ex_imm_r <= 16'h0000;
      ex_part_r <= PART_LOW;
      ex_pc_r <= 16'h0000;
      ex_addr_r <= 16'h0000;
      ex_a_r <= 40'h0000000000;
      ex_b_r <= 40'h0000000000;
      ex_d_r <= 40'h0000000000;
    end else if (run) begin
      ex_v_r <= if_v_r && !kill;
      ex_op_r <= id_op;
      ex_dst_r <= id_dst;
      ex_imm_r <= instr_in[15:0];
      ex_part_r <= instr_in[PART_LSB +: 2];
      ex_pc_r <= if_pc_r;
      ex_addr_r <= dp_r[id_sb];
      ex_a_r <= fwd(id_sa);
      ex_b_r <= fwd(id_sb);
      ex_d_r <= fwd(id_dst);
    end else begin
      ex_v_r <= 1'b0;
    end
  end

  // Register file and data memory ports
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_GPR; i++) gpr_r[i] <= 40'h0000000000;
      res_we_out <= 1'b0;
      res_idx_out <= 3'h0;
      res_data_out <= 40'h0000000000;
    end else begin
      if (run && ex_wr) gpr_r[ex_dst_r] <= ex_result;
      res_we_out <= run && ex_wr;
      res_idx_out <= ex_dst_r;
      res_data_out <= ex_result;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_en_out <= 1'b0;
      rd_addr_out <= 16'h0000;
      wr_en_out <= 1'b0;
      wr_addr_out <= 16'h0000;
      wr_data_out <= 16'h0000;
    end else begin
      rd_en_out <= run && if_v_r && !kill && id_op == OP_LD;
      rd_addr_out <= dp_r[id_sb];
      wr_en_out <= run && ex_v_r && ex_op_r == OP_ST;
      wr_addr_out <= ex_addr_r;
      wr_data_out <= store_view(ex_part_r, ex_a_r);
    end
  end

  // Data pointers, written late so the next decode still sees the old value
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_DP; i++) dp_r[i] <= 16'h0000;
    end else if (run && ex_v_r) begin
      if (ex_op_r == OP_DPI) dp_r[ex_dst_r] <= ex_imm_r;
      else if (ex_op_r == OP_DPR) dp_r[ex_dst_r] <= ex_a_r[15:0];
    end
  end

  // Return stack
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CALL_DEPTH; i++) cstk_r[i] <= 16'h0000;
      csp_r <= 4'h0;
      stack_fault_out <= 1'b0;
    end else if (irq_take || (redirect && ex_op_r == OP_CALL)) begin
      if (csp_r < 4'(CALL_DEPTH)) begin
        cstk_r[csp_r] <= irq_take ? (if_v_r ? if_pc_r : pc_r) : ex_pc_r + 16'h0001;
        csp_r <= csp_r + 4'h1;
      end else stack_fault_out <= 1'b1;
    end else if (redirect && ex_op_r inside {OP_RET, OP_RETI}) begin
      if (csp_r != 4'h0) csp_r <= csp_r - 4'h1;
      else stack_fault_out <= 1'b1;
    end
  end

  // Loop stack
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LOOP_DEPTH; i++) begin
        lstart_r[i] <= 16'h0000;
        lend_r[i] <= 16'h0000;
        lcnt_r[i] <= 16'h0000;
      end
      lsp_r <= 3'h0;
    end else if (run && ex_v_r && ex_op_r == OP_LOOP && lsp_r < 3'(LOOP_DEPTH)) begin
      lstart_r[lsp_r[1:0]] <= ex_pc_r + 16'h0001;
      lend_r[lsp_r[1:0]] <= ex_imm_r;
      lcnt_r[lsp_r[1:0]] <= ex_a_r[15:0];
      lsp_r <= lsp_r + 3'h1;
    end else if (loop_hit) begin
      if (lcnt_r[ltop] > 16'h0001) lcnt_r[ltop] <= lcnt_r[ltop] - 16'h0001;
      else lsp_r <= lsp_r - 3'h1;
    end
  end

  // Interrupt sources
  always_comb begin
    irq_idx = 4'h0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) if (irq_vec[i]) irq_idx = 4'(i);
  end
  assign ext_fall = ext_lvl_r & ~ext_s2_r & ~ext_s3_r;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_r <= 4'hF;
      ext_s2_r <= 4'hF;
      ext_s3_r <= 4'hF;
      ext_lvl_r <= 4'hF;
    end else begin
      ext_s1_r <= ext_irq_n_in;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      for (int i = 0; i < NUM_EXT_IRQ; i++) if (ext_s2_r[i] == ext_s3_r[i]) ext_lvl_r[i] <= ext_s3_r[i];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_pend_r <= 10'h000;
      irq_en_r <= IRQ_EN_RESET;
      gie_r <= 1'b1;
    end else begin
      irq_pend_r <= (irq_pend_r & ~(irq_take ? 10'(10'h001 << irq_idx) : 10'h000))
                    | {periph_irq_in, ext_fall};
      if (run && ex_v_r && ex_op_r == OP_IEN) irq_en_r <= ex_imm_r[NUM_IRQ-1:0];
      if (irq_take) gie_r <= 1'b0;
      else if (redirect && ex_op_r == OP_RETI) gie_r <= 1'b1;
    end
  end

  // Checks
  sequence s_wake_req;
    halted_out && (|irq_vec);
  endsequence
  sequence s_back_to_run;
    ##[1:WAKE_BOUND] run;
  endsequence

  a_pipe_advance: assert property (@(posedge clk_in) disable iff (!rst_n)
    run && if_v_r && !kill |=> ex_v_r && ex_pc_r == $past(if_pc_r))
    else $error("decoded instruction did not reach execute");
  a_fwd_result: assert property (@(posedge clk_in) disable iff (!rst_n)
    run && if_v_r && ex_wr && ex_dst_r == id_sa |=> ex_a_r == $past(ex_result))
    else $error("previous result not forwarded");
  a_irq_ctrl_delay: assert property (@(posedge clk_in) disable iff (!rst_n)
    run && ex_v_r && ex_op_r == OP_IEN |=> irq_en_r == $past(ex_imm_r[NUM_IRQ-1:0]))
    else $error("interrupt enables not updated at execute");
  a_dp_late: assert property (@(posedge clk_in) disable iff (!rst_n)
    run && ex_v_r && ex_op_r == OP_DPI && if_v_r && id_sb == ex_dst_r |=> ex_addr_r != $past(ex_imm_r)
      || $past(dp_r[ex_dst_r]) == $past(ex_imm_r))
    else $error("pointer usable too early");
  a_stack_bounds: assert property (@(posedge clk_in) disable iff (!rst_n)
    csp_r <= 4'(CALL_DEPTH) && lsp_r <= 3'(LOOP_DEPTH))
    else $error("stack pointer beyond depth");
  a_irq_enabled: assert property (@(posedge clk_in) disable iff (!rst_n)
    irq_take |-> irq_en_r[irq_idx] && irq_pend_r[irq_idx] ##1 !irq_pend_r[$past(irq_idx)] || $past(irq_idx) < 4'h4)
    else $error("disabled interrupt taken");
  a_halt_wake: assert property (@(posedge clk_in) disable iff (!rst_n)
    s_wake_req |-> s_back_to_run)
    else $error("halt not released by interrupt");
  a_stop_holds: assert property (@(posedge clk_in) disable iff (!rst_n)
    stopped_out |=> stopped_out && !run)
    else $error("stop left without reset");
  a_mac_uu: assert property (@(posedge clk_in) disable iff (!rst_n)
    ex_op_r == OP_MAC && ex_imm_r[4:0] == 5'h02 |->
      ex_result == ex_d_r + {8'h00, 32'(ex_a_r[15:0]) * 32'(ex_b_r[15:0])})
    else $error("unsigned product accumulated wrongly");
  a_sext_load: assert property (@(posedge clk_in) disable iff (!rst_n)
    ex_op_r == OP_LD && ex_part_r == PART_SEXT |-> ex_result[39:16] == {{8{rd_data_in[15]}}, rd_data_in}
      && ex_result[15:0] == 16'h0000)
    else $error("sign-extending load wrong");
endmodule : dsp_core_operation_unit

// [common/dsp_core_pkg.sv]
package dsp_core_pkg;
  // Data path sizes
  localparam int GPR_W = 40;
  localparam int HALF_W = 16;
  localparam int NUM_GPR = 8;
  localparam int NUM_DP = 8;
  localparam int LOOP_DEPTH = 4;
  localparam int CALL_DEPTH = 15;
  localparam int NUM_EXT_IRQ = 4;
  localparam int NUM_INT_IRQ = 6;
  localparam int NUM_IRQ = NUM_EXT_IRQ + NUM_INT_IRQ;
  // Instruction word fields
  localparam int OPC_LSB = 27;
  localparam int DST_LSB = 24;
  localparam int SA_LSB = 21;
  localparam int SB_LSB = 18;
  localparam int PART_LSB = 16;
  localparam int MUL_MODE_LSB = 0;
  localparam int MAC_SUB_BIT = 2;
  localparam int MAC_SH_LSB = 3;
  // Opcodes
  localparam logic [4:0] OP_NOP = 5'h00;
  localparam logic [4:0] OP_MAC = 5'h01;
  localparam logic [4:0] OP_ADD = 5'h02;
  localparam logic [4:0] OP_SUB = 5'h03;
  localparam logic [4:0] OP_SHR = 5'h04;
  localparam logic [4:0] OP_EXP = 5'h05;
  localparam logic [4:0] OP_LDI = 5'h06;
  localparam logic [4:0] OP_LD = 5'h07;
  localparam logic [4:0] OP_ST = 5'h08;
  localparam logic [4:0] OP_DPI = 5'h09;
  localparam logic [4:0] OP_DPR = 5'h0A;
  localparam logic [4:0] OP_JMP = 5'h0B;
  localparam logic [4:0] OP_CALL = 5'h0C;
  localparam logic [4:0] OP_RET = 5'h0D;
  localparam logic [4:0] OP_LOOP = 5'h0E;
  localparam logic [4:0] OP_IEN = 5'h0F;
  localparam logic [4:0] OP_HALT = 5'h10;
  localparam logic [4:0] OP_STOP = 5'h11;
  localparam logic [4:0] OP_RETI = 5'h12;
  // Register views for load/store
  localparam logic [1:0] PART_LOW = 2'h0;
  localparam logic [1:0] PART_HIGH = 2'h1;
  localparam logic [1:0] PART_GUARD = 2'h2;
  localparam logic [1:0] PART_SEXT = 2'h3;
  // Multiplier signedness and pre-shift
  localparam logic [1:0] MUL_SS = 2'h0;
  localparam logic [1:0] MUL_SU = 2'h1;
  localparam logic [1:0] MUL_UU = 2'h2;
  localparam logic [1:0] SH_NONE = 2'h0;
  localparam logic [1:0] SH_1 = 2'h1;
  localparam logic [1:0] SH_16 = 2'h2;
  // Reset values and vectors
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] VEC_BASE = 16'h0040;
  localparam logic [NUM_IRQ-1:0] IRQ_EN_RESET = 10'h000;
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int HALT_WAKE_CYCLES = 8;
  localparam int STOP_RECOVER_US = 2000;
  localparam int STOP_RECOVER_CYCLES = STOP_RECOVER_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {ST_BOOT, ST_RUN, ST_HALT, ST_WAKE, ST_STOP} core_state_t;
endpackage : dsp_core_pkg

// [verification/dsp_core_operation_unit_tb.sv]
module dsp_core_operation_unit_tb
  import dsp_core_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_in = 1'b0;
  logic nrst_in;
  logic [15:0] pc_out;
  logic [31:0] instr_in = 32'h0000_0000;
  logic rd_en_out;
  logic [15:0] rd_addr_out;
  logic [15:0] rd_data_in;
  logic wr_en_out;
  logic [15:0] wr_addr_out;
  logic [15:0] wr_data_out;
  logic [NUM_EXT_IRQ-1:0] ext_irq_n_in;
  logic [NUM_INT_IRQ-1:0] periph_irq_in;
  logic res_we_out;
  logic [2:0] res_idx_out;
  logic [GPR_W-1:0] res_data_out;
  logic halted_out;
  logic stopped_out;
  logic stack_fault_out;
  logic [31:0] im [0:255];
  logic [15:0] dm [0:255];
  logic [2:0] wi [$];
  logic [GPR_W-1:0] wv [$];
  logic [15:0] rq [$];
  logic [15:0] wa [$];
  logic [15:0] wd [$];
  int errors;
  int num_checks;

  dsp_core_operation_unit #(.RECOVER_CYCLES(20)) dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .pc_out(pc_out), .instr_in(instr_in),
    .rd_en_out(rd_en_out), .rd_addr_out(rd_addr_out), .rd_data_in(rd_data_in),
    .wr_en_out(wr_en_out), .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out),
    .ext_irq_n_in(ext_irq_n_in), .periph_irq_in(periph_irq_in), .res_we_out(res_we_out),
    .res_idx_out(res_idx_out), .res_data_out(res_data_out), .halted_out(halted_out),
    .stopped_out(stopped_out), .stack_fault_out(stack_fault_out)
  );

  always #2 clk_in = ~clk_in;

  // Instruction memory answers one cycle after the address
  always @(posedge clk_in) begin
    instr_in <= im[pc_out[7:0]];
  end

  // Load data must be valid while the read strobe is high
  assign rd_data_in = dm[rd_addr_out[7:0]];

  always @(posedge clk_in) begin
    if (res_we_out === 1'b1) begin
      wi.push_back(res_idx_out);
      wv.push_back(res_data_out);
    end
    if (rd_en_out === 1'b1) begin
      rq.push_back(rd_addr_out);
    end
    if (wr_en_out === 1'b1) begin
      wa.push_back(wr_addr_out);
      wd.push_back(wr_data_out);
    end
  end

  function automatic logic [31:0] ins(input logic [4:0] op, input logic [2:0] d, input logic [2:0] a,
                                      input logic [2:0] b, input logic [1:0] p, input logic [15:0] v);
    ins = {op, d, a, b, p, v};
  endfunction : ins

  function automatic int cnt(input logic [2:0] idx);
    cnt = 0;
    foreach (wi[i]) if (wi[i] === idx) cnt++;
  endfunction : cnt

  function automatic logic [GPR_W-1:0] nth(input logic [2:0] idx, input int n);
    int k = 0;
    nth = {GPR_W{1'bx}};
    foreach (wi[i]) begin
      if (wi[i] === idx) begin
        if (k == n) nth = wv[i];
        k++;
      end
    end
  endfunction : nth

  task automatic cmp40(input string what, input logic [GPR_W-1:0] exp, input logic [GPR_W-1:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : cmp40

  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : cmp16

  task automatic cmp1(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s: expected %b, seen %b", what, exp, got);
    end
  endtask : cmp1

  task automatic wrap_up();
    $display("checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  task automatic timeout(input string what);
    errors++;
    $display("wrong value wait for %s: expected done, seen timeout", what);
    wrap_up();
  endtask : timeout

  task automatic fill(input logic [31:0] w);
    for (int i = 0; i < 256; i++) im[i] = w;
  endtask : fill

  task automatic run(input int lim);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    wi.delete(); wv.delete(); rq.delete(); wa.delete(); wd.delete();
    nrst_in <= 1'b1;
    for (int i = 0; i < lim; i++) begin
      @(posedge clk_in);
      if (halted_out === 1'b1 || stopped_out === 1'b1) return;
    end
    timeout("standby");
  endtask : run

  task automatic wait_cnt(input logic [2:0] idx, input int n, input int lim, input bit must);
    for (int i = 0; i < lim; i++) begin
      @(posedge clk_in);
      if (cnt(idx) >= n) return;
    end
    if (must) timeout("register write");
  endtask : wait_cnt

  // Pointer delay, partial views, back-to-back use of a result
  task automatic t_load();
    fill(32'h0000_0000);
    dm[8'h10] = 16'h8001;
    dm[8'h20] = 16'h1234;
    im[0] = ins(OP_DPI, 3'h3, 3'h0, 3'h0, 2'h0, 16'h0010);
    im[1] = ins(OP_DPI, 3'h3, 3'h0, 3'h0, 2'h0, 16'h0020);
    im[2] = ins(OP_LD, 3'h1, 3'h0, 3'h3, PART_SEXT, 16'h0000);
    im[3] = ins(OP_LD, 3'h2, 3'h0, 3'h3, PART_SEXT, 16'h0000);
    im[4] = ins(OP_LDI, 3'h1, 3'h0, 3'h0, 2'h0, 16'h0005);
    im[5] = ins(OP_LDI, 3'h2, 3'h0, 3'h0, 2'h0, 16'hFFFF);
    im[6] = ins(OP_ADD, 3'h3, 3'h1, 3'h2, 2'h0, 16'h0000);
    im[7] = ins(OP_ST, 3'h0, 3'h3, 3'h3, PART_GUARD, 16'h0000);
    im[8] = ins(OP_ST, 3'h0, 3'h3, 3'h3, PART_HIGH, 16'h0000);
    im[9] = ins(OP_HALT, 3'h0, 3'h0, 3'h0, 2'h0, 16'h0000);
    run(200);
    repeat (4) @(posedge clk_in);
    cmp16("first load address", 16'h0010, rq[0]);
    cmp16("second load address", 16'h0020, rq[1]);
    cmp40("r1", 40'hFF_8001_0005, nth(3'h1, 1));
    cmp40("r2", 40'h00_1234_FFFF, nth(3'h2, 1));
    cmp40("r3 sum", 40'hFF_9236_0004, nth(3'h3, 0));
    cmp16("guard store", 16'h00FF, wd[0]);
    cmp16("high store", 16'h9236, wd[1]);
    cmp16("store address", 16'h0020, wa[1]);
  endtask : t_load

  // Each signedness, add and subtract, each pre-shift, chained
  task automatic t_mac();
    fill(32'h0000_0000);
    dm[8'h30] = 16'hFFFE;
    dm[8'h31] = 16'h0004;
    dm[8'h32] = 16'h0000;
    for (int i = 0; i < 3; i++) begin
      im[i] = ins(OP_DPI, 3'(i), 3'h0, 3'h0, 2'h0, 16'h0030 + 16'(i));
      im[3 + i] = ins(OP_LD, 3'(i + 1) % 3'h3, 3'h0, 3'(i), PART_SEXT, 16'h0000);
    end
    im[6] = ins(OP_LDI, 3'h1, 3'h0, 3'h0, 2'h0, 16'h0003);
    im[7] = ins(OP_LDI, 3'h2, 3'h0, 3'h0, 2'h0, 16'hFFFF);
    im[8] = ins(OP_LDI, 3'h0, 3'h0, 3'h0, 2'h0, 16'h0100);
    im[9] = ins(OP_MAC, 3'h0, 3'h1, 3'h2, 2'h0, 16'h0000);
    im[10] = ins(OP_MAC, 3'h0, 3'h1, 3'h2, 2'h0, 16'h000D);
    im[11] = ins(OP_MAC, 3'h0, 3'h1, 3'h2, 2'h0, 16'h0012);
    im[12] = ins(OP_MAC, 3'h0, 3'h1, 3'h2, 2'h0, 16'h0002);
    im[13] = ins(OP_EXP, 3'h4, 3'h1, 3'h0, 2'h0, 16'h0000);
    im[14] = ins(OP_SHR, 3'h6, 3'h1, 3'h1, 2'h0, 16'h0000);
    im[15] = ins(OP_HALT, 3'h0, 3'h0, 3'h0, 2'h0, 16'h0000);
    run(200);
    cmp40("r0 start", 40'h00_0000_0100, nth(3'h0, 1));
    cmp40("mac signed", 40'h00_0000_00F8, nth(3'h0, 2));
    cmp40("mac mixed sub", 40'h00_0001_00F7, nth(3'h0, 3));
    cmp40("mac unsigned", 40'h00_0001_00F9, nth(3'h0, 4));
    cmp40("mac unsigned plain", 40'h00_0004_00F6, nth(3'h0, 5));
    cmp40("exponent", 40'h00_0000_000E, nth(3'h4, 0));
    cmp40("shift right", 40'hFF_FFFF_C000, nth(3'h6, 0));
  endtask : t_mac

  task automatic t_loop();
    fill(32'h0000_0000);
    im[0] = ins(OP_LDI, 3'h1, 3'h0, 3'h0, 2'h0, 16'h0003);
    // Body of three words: a shorter body is already at its end when the loop executes
    im[2] = ins(OP_LOOP, 3'h0, 3'h1, 3'h0, 2'h0, 16'h0005);
    im[3] = ins(OP_LDI, 3'h6, 3'h0, 3'h0, 2'h0, 16'h0055);
    im[4] = ins(OP_LDI, 3'h7, 3'h0, 3'h0, 2'h0, 16'h00AA);
    im[6] = ins(OP_HALT, 3'h0, 3'h0, 3'h0, 2'h0, 16'h0000);
    run(200);
    cmp16("loop passes", 16'h0003, 16'(cnt(3'h6)));
  endtask : t_loop

  // Chain of calls, optionally closed by a return, which has nothing pushed when the chain is empty
  task automatic t_stack(input int n, input bit ret, input logic exp);
    fill(ins(OP_HALT, 3'h0, 3'h0, 3'h0, 2'h0, 16'h0000));
    for (int k = 0; k < n; k++) im[k] = ins(OP_CALL, 3'h0, 3'h0, 3'h0, 2'h0, 16'(k + 1));
    if (ret) im[n] = ins(OP_RET, 3'h0, 3'h0, 3'h0, 2'h0, 16'h0000);
    run(300);
    cmp1("stack fault", exp, stack_fault_out);
  endtask : t_stack

  task automatic t_irq(input logic [15:0] en, input int n1);
    fill(32'h0000_0000);
    im[0] = ins(OP_IEN, 3'h0, 3'h0, 3'h0, 2'h0, en);
    im[3] = ins(OP_HALT, 3'h0, 3'h0, 3'h0, 2'h0, 16'h0000);
    im[4] = ins(OP_JMP, 3'h0, 3'h0, 3'h0, 2'h0, 16'h0003);
    for (int i = 0; i < NUM_IRQ; i++) begin
      im[64 + 4 * i] = ins(OP_LDI, 3'h5, 3'h0, 3'h0, 2'h0, 16'h0100 + 16'(i));
      im[65 + 4 * i] = ins(OP_RETI, 3'h0, 3'h0, 3'h0, 2'h0, 16'h0000);
    end
    run(200);
    cmp1("halted", 1'b1, halted_out);
    periph_irq_in <= 6'h0A;
    @(posedge clk_in);
    periph_irq_in <= 6'h00;
    wait_cnt(3'h5, (n1 > 0) ? n1 : 1, 60, n1 > 0);
    repeat (20) @(posedge clk_in);
    cmp1("halted before pin", 1'b1, halted_out);
    ext_irq_n_in <= 4'hB;
    repeat (4) @(posedge clk_in);
    ext_irq_n_in <= 4'hF;
    wait_cnt(3'h5, n1 + 1, 80, 1'b1);
    repeat (30) @(posedge clk_in);
    cmp16("taken count", 16'(n1 + 1), 16'(cnt(3'h5)));
    if (n1 > 0) cmp40("lowest first", 40'h00_0000_0105, nth(3'h5, 0));
    if (n1 > 0) cmp40("second source", 40'h00_0000_0107, nth(3'h5, 1));
    cmp40("pin source", 40'h00_0000_0102, nth(3'h5, n1));
    cmp1("halted again", 1'b1, halted_out);
  endtask : t_irq

  task automatic t_stop();
    logic [15:0] p;
    fill(32'h0000_0000);
    im[0] = ins(OP_IEN, 3'h0, 3'h0, 3'h0, 2'h0, 16'h03FF);
    im[3] = ins(OP_STOP, 3'h0, 3'h0, 3'h0, 2'h0, 16'h0000);
    run(200);
    p = pc_out;
    cmp1("stopped", 1'b1, stopped_out);
    periph_irq_in <= 6'h3F;
    ext_irq_n_in <= 4'h0;
    repeat (6) @(posedge clk_in);
    periph_irq_in <= 6'h00;
    ext_irq_n_in <= 4'hF;
    repeat (40) @(posedge clk_in);
    cmp1("still stopped", 1'b1, stopped_out);
    cmp16("frozen fetch", p, pc_out);
    cmp16("no wake writes", 16'h0000, 16'(wi.size()));
  endtask : t_stop

  initial begin
    nrst_in = 1'b0;
    ext_irq_n_in = 4'hF;
    periph_irq_in = 6'h00;
    errors = 0;
    num_checks = 0;
    t_load();
    t_mac();
    t_loop();
    t_stack(CALL_DEPTH, 1'b0, 1'b0);
    t_stack(CALL_DEPTH + 1, 1'b0, 1'b1);
    t_stack(0, 1'b1, 1'b1);
    t_irq(16'h03FF, 2);
    t_irq(16'h0004, 0);
    t_stop();
    fill(ins(OP_HALT, 3'h0, 3'h0, 3'h0, 2'h0, 16'h0000));
    run(200);
    cmp1("stop left by reset", 1'b0, stopped_out);
    wrap_up();
  end
endmodule : dsp_core_operation_unit_tb
